// ==== logic/spll_regs.vh ====
// Purpose: constants for the sector protection and lock logic
// Assumes: plain Verilog-2005 includes this file once per module file
// Notes:   opcodes other than the sector protection read are free choices
`ifndef SPLL_REGS_VH
`define SPLL_REGS_VH

// ==========================================================
// command opcodes
`define SPLL_OP_RD_SECT   8'h3c
`define SPLL_OP_WR_STAT   8'h01
`define SPLL_OP_RD_STAT   8'h05
`define SPLL_OP_PROT_SEC  8'h36
`define SPLL_OP_UNPR_SEC  8'h39

// ==========================================================
// first status byte layout
`define SPLL_STAT_LOCK    7
`define SPLL_STAT_WP      4
`define SPLL_STAT_SUM_HI  3
`define SPLL_STAT_SUM_LO  2
`define SPLL_GLOB_HI      5
`define SPLL_GLOB_LO      2
`define SPLL_GLOB_UNPROT  4'h0
`define SPLL_GLOB_PROT    4'hf

// ==========================================================
// protection summary codes
`define SPLL_SUM_NONE     2'h0
`define SPLL_SUM_SOME     2'h1
`define SPLL_SUM_ALL      2'h3

// ==========================================================
// sector read answers and reset values
`define SPLL_BYTE_UNPROT  8'h00
`define SPLL_BYTE_PROT    8'hff
`define SPLL_NSECT        4
`define SPLL_PROT_RESET   1'b1
`define SPLL_LOCK_RESET   1'b0

// ==========================================================
// framing counts
`define SPLL_BITS_LAST    3'h7
`define SPLL_ADDR_LAST    2'h2

`endif

// ==== logic/spll_sync.v ====
// Purpose: two flip-flop synchroniser for the pin inputs
// Assumes: pins are asynchronous to clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module spll_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clock,
  input  wire         rst,
  // pins in, synchronised out
  input  wire [W-1:0] pin_in,
  input  wire [W-1:0] pin_rst_val,
  output wire [W-1:0] pin_sync
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // ==========================================================
  // one pair of flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          meta_reg[gi] <= 1'b1; // reset loads 1 into every pin flop, the idle level of cs_n and wp_n
          sync_reg[gi] <= 1'b1;
        end else begin
          meta_reg[gi] <= pin_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  // reset value port is unused by the flops; kept only as a width check
  assign pin_sync = sync_reg | (pin_rst_val & {W{1'b0}});

endmodule

// ==== logic/spll_bank.v ====
// Purpose: bank of sector protection bits
// Assumes: at most one of the update pulses is high in a cycle
// Notes:   global pulses win over a single sector pulse
`timescale 1ns/1ns
`include "spll_regs.vh"
module spll_bank (
  // clock and reset
  input  wire                     clock,
  input  wire                     rst,
  // update pulses
  input  wire                     glob_set,
  input  wire                     glob_clr,
  input  wire                     sec_set,
  input  wire                     sec_clr,
  input  wire [1:0]               sec_idx,
  // protection state
  output reg  [`SPLL_NSECT-1:0]   prot_reg
);

  // ==========================================================
  // one protection flop per sector
  genvar gs;
  generate
    for (gs = 0; gs < `SPLL_NSECT; gs = gs + 1) begin : g_sect
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          prot_reg[gs] <= `SPLL_PROT_RESET;
        end else if (glob_set) begin
          prot_reg[gs] <= 1'b1;
        end else if (glob_clr) begin
          prot_reg[gs] <= 1'b0;
        end else if (sec_idx == gs) begin
          if (sec_set) begin
            prot_reg[gs] <= 1'b1;
          end else if (sec_clr) begin
            prot_reg[gs] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

// ==== logic/spll_top.v ====
// Purpose: sector protection and locking logic behind the serial pins
// Assumes: serial mode 0, pins sampled by a clock much faster than sclk
// Notes:   write enable, busy and array access live elsewhere
//
// What this block does
// - lock clear, status write 00h clears every sector protection bit, lock stays 0.
// - lock clear, status write 7Fh sets every sector protection bit, lock stays 0.
// - lock clear, status write FFh sets every protection bit and sets lock.
// - status write 0Fh clears lock without global change when pin is high.
// - status write F0h sets lock and leaves protection bits alone.
// - only bit 7 of a status write is stored; bits 5..2 only decode.
// - status read bits 4..2 show pin level and protection summary.
// - soft-locked status write skips global action but may clear lock.
// - opcode 3Ch plus three address bytes starts a sector protection read.
// - sector read returns repeating 00h when unprotected, FFh when protected.
// - chip select rising ends the read at once and floats the output.
// - sector read data carries no write-protect pin information.
// - hardware lock is active only with pin low and lock bit 1.
// - hardware lock ignores sector protect, unprotect and status writes.
// - write clearing lock from 1 to 0 applies no global action.
// - reset leaves every sector protected and the lock bit clear.
// - lock bit 1 with pin high ignores sector protect and unprotect.
// - write raising lock from 0 to 1 also applies its global action.
// - pin never changes protection; a sector is protected when its bit is 1.
// - global unprotect clears all bits, global protect sets all, others keep.
`timescale 1ns/1ns
`include "spll_regs.vh"
module spll_top (
  // clock and reset
  input  wire                   clock,
  input  wire                   rst,
  // serial pins
  input  wire                   sclk,
  input  wire                   cs_n,
  input  wire                   si,
  input  wire                   wp_n,
  output reg                    so_out_reg,
  output reg                    so_oe_reg,
  // protection state
  output wire [`SPLL_NSECT-1:0] sector_protect,
  output reg                    protection_lock_bit,
  output reg                    hw_lock_reg,
  output reg  [1:0]             software_protection_summary
);

  // ==========================================================
  // frame states
  localparam [2:0] ST_OPC  = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_OUT  = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;

  // ==========================================================
  // synchronised pins
  wire [3:0] pins_sync;
  wire       sclk_s;
  wire       cs_n_s;
  wire       si_s;
  wire       wp_n_s;

  spll_sync #(
    .W(4)
  ) u_sync (
    .clock       (clock),
    .rst         (rst),
    .pin_in      ({wp_n, si, cs_n, sclk}),
    .pin_rst_val (4'hf),
    .pin_sync    (pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign cs_n_s = pins_sync[1];
  assign si_s   = pins_sync[2];
  assign wp_n_s = pins_sync[3];

  // ==========================================================
  // state registers
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg       sclk_d_reg;
  reg [6:0] shift_reg;
  reg [2:0] bit_reg;
  reg [1:0] addr_cnt_reg;
  reg [1:0] addr_cnt_next;
  reg [7:0] opc_reg;
  reg [7:0] opc_next;
  reg [1:0] sec_idx_reg;
  reg [1:0] sec_idx_next;
  reg [2:0] out_bit_reg;
  reg [7:0] out_byte_reg;
  reg       out_stat_reg;
  reg       out_stat_next;
  reg       load_out_next;
  reg       lock_next;
  reg       glob_set_reg;
  reg       glob_set_next;
  reg       glob_clr_reg;
  reg       glob_clr_next;
  reg       sec_set_reg;
  reg       sec_set_next;
  reg       sec_clr_reg;
  reg       sec_clr_next;

  wire       rise;
  wire       fall;
  wire       byte_done;
  wire [7:0] byte_in;
  wire [3:0] glob_code;
  wire       hw_lock;
  wire [7:0] stat_byte;
  wire [7:0] sect_byte;
  wire       sel_prot;

  // edges are found on the second synchroniser stage only
  assign rise      = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign fall      = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign byte_done = rise & (bit_reg == `SPLL_BITS_LAST);
  assign byte_in   = {shift_reg, si_s};
  assign glob_code = byte_in[`SPLL_GLOB_HI:`SPLL_GLOB_LO];

  // hardware lock needs both the pin low and the lock bit set
  assign hw_lock = ~wp_n_s & protection_lock_bit;

  // ==========================================================
  // answer bytes
  // status byte: lock, pin level and summary; written bits 5..2 never show
  assign stat_byte = {protection_lock_bit, 2'h0, wp_n_s,
                      software_protection_summary, 2'h0};
  // sector byte is built from the protection bit alone, pin not used
  assign sel_prot  = sector_protect[sec_idx_reg];
  assign sect_byte = sel_prot ? `SPLL_BYTE_PROT : `SPLL_BYTE_UNPROT;

  // ==========================================================
  // protection bits
  spll_bank u_bank (
    .clock    (clock),
    .rst      (rst),
    .glob_set (glob_set_reg),
    .glob_clr (glob_clr_reg),
    .sec_set  (sec_set_reg),
    .sec_clr  (sec_clr_reg),
    .sec_idx  (sec_idx_reg),
    .prot_reg (sector_protect)
  );

  // ==========================================================
  // command decode on each completed byte
  always @* begin
    state_next    = state_reg;
    addr_cnt_next = addr_cnt_reg;
    opc_next      = opc_reg;
    sec_idx_next  = sec_idx_reg;
    out_stat_next = out_stat_reg;
    load_out_next = 1'b0;
    lock_next     = protection_lock_bit;
    glob_set_next = 1'b0;
    glob_clr_next = 1'b0;
    sec_set_next  = 1'b0;
    sec_clr_next  = 1'b0;
    if (byte_done) begin
      case (state_reg)
        ST_OPC: begin
          opc_next      = byte_in;
          addr_cnt_next = 2'h0;
          case (byte_in)
            `SPLL_OP_RD_STAT: begin
              state_next    = ST_OUT;
              out_stat_next = 1'b1;
              load_out_next = 1'b1;
            end
            `SPLL_OP_WR_STAT: begin
              state_next = ST_DATA;
            end
            `SPLL_OP_RD_SECT,
            `SPLL_OP_PROT_SEC,
            `SPLL_OP_UNPR_SEC: begin
              state_next = ST_ADDR;
            end
            default: begin
              state_next = ST_SKIP;
            end
          endcase
        end
        ST_ADDR: begin
          addr_cnt_next = addr_cnt_reg + 2'h1;
          // first address byte holds A23..A16; A17..A16 pick the sector
          if (addr_cnt_reg == 2'h0) begin
            sec_idx_next = byte_in[1:0];
          end
          if (addr_cnt_reg == `SPLL_ADDR_LAST) begin
            if (opc_reg == `SPLL_OP_RD_SECT) begin
              state_next    = ST_OUT;
              out_stat_next = 1'b0;
              load_out_next = 1'b1;
            end else begin
              state_next = ST_SKIP;
              // any lock, soft or hard, freezes single sector updates
              if (!protection_lock_bit) begin
                sec_set_next = (opc_reg == `SPLL_OP_PROT_SEC);
                sec_clr_next = (opc_reg == `SPLL_OP_UNPR_SEC);
              end
            end
          end
        end
        ST_DATA: begin
          state_next = ST_SKIP;
          if (hw_lock) begin
            lock_next = protection_lock_bit;
          end else if (protection_lock_bit) begin
            // soft lock: only the lock bit moves, global is withheld
            lock_next = byte_in[`SPLL_STAT_LOCK];
          end else begin
            // unlocked: lock bit stored, global applied with it
            lock_next     = byte_in[`SPLL_STAT_LOCK];
            glob_clr_next = (glob_code == `SPLL_GLOB_UNPROT);
            glob_set_next = (glob_code == `SPLL_GLOB_PROT);
          end
        end
        ST_OUT: begin
          state_next = ST_OUT;
        end
        ST_SKIP: begin
          state_next = ST_SKIP;
        end
        default: begin
          state_next = ST_SKIP;
        end
      endcase
    end
  end

  // ==========================================================
  // frame sequencing on the sampled serial clock
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_OPC;
      sclk_d_reg   <= 1'b1;
      shift_reg    <= 7'h00;
      bit_reg      <= 3'h0;
      addr_cnt_reg <= 2'h0;
      opc_reg      <= 8'h00;
      sec_idx_reg  <= 2'h0;
      out_stat_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      if (cs_n_s) begin
        // deselect drops the frame wherever it stood, mid-byte too
        state_reg    <= ST_OPC;
        bit_reg      <= 3'h0;
        addr_cnt_reg <= 2'h0;
      end else begin
        state_reg    <= state_next;
        addr_cnt_reg <= addr_cnt_next;
        opc_reg      <= opc_next;
        sec_idx_reg  <= sec_idx_next;
        out_stat_reg <= out_stat_next;
        if (rise) begin
          shift_reg <= byte_in[6:0];
          bit_reg   <= bit_reg + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // lock bit and update pulses
  // pulses land one cycle after the byte so the bank sees a clean strobe
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      protection_lock_bit <= `SPLL_LOCK_RESET;
      glob_set_reg        <= 1'b0;
      glob_clr_reg        <= 1'b0;
      sec_set_reg         <= 1'b0;
      sec_clr_reg         <= 1'b0;
    end else begin
      protection_lock_bit <= cs_n_s ? protection_lock_bit : lock_next;
      glob_set_reg        <= glob_set_next & ~cs_n_s;
      glob_clr_reg        <= glob_clr_next & ~cs_n_s;
      sec_set_reg         <= sec_set_next & ~cs_n_s;
      sec_clr_reg         <= sec_clr_next & ~cs_n_s;
    end
  end

  // ==========================================================
  // status outputs; the pin only feeds the lock flag, never the bits
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_lock_reg                 <= 1'b0;
      software_protection_summary <= `SPLL_SUM_ALL;
    end else begin
      hw_lock_reg <= hw_lock;
      if (&sector_protect) begin
        software_protection_summary <= `SPLL_SUM_ALL;
      end else if (|sector_protect) begin
        software_protection_summary <= `SPLL_SUM_SOME;
      end else begin
        software_protection_summary <= `SPLL_SUM_NONE;
      end
    end
  end

  // ==========================================================
  // serial output, one bit per falling edge, msb first
  // the byte is refreshed at each wrap so a long read tracks live state
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      so_out_reg   <= 1'b0;
      so_oe_reg    <= 1'b0;
      out_bit_reg  <= 3'h0;
      out_byte_reg <= 8'h00;
    end else if (cs_n_s) begin
      so_out_reg  <= 1'b0;
      so_oe_reg   <= 1'b0;
      out_bit_reg <= 3'h0;
    end else if (load_out_next) begin
      out_bit_reg  <= 3'h0;
      out_byte_reg <= out_stat_next ? stat_byte : sect_byte;
    end else if (fall && state_reg == ST_OUT) begin
      so_oe_reg   <= 1'b1;
      so_out_reg  <= out_byte_reg[3'h7 - out_bit_reg];
      out_bit_reg <= out_bit_reg + 3'h1;
      if (out_bit_reg == `SPLL_BITS_LAST) begin
        out_byte_reg <= out_stat_reg ? stat_byte : sect_byte;
      end
    end
  end

endmodule

// ==== bench/spll_properties.sv ====
// Purpose: port-level checks of the sector protection and lock block
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   pin paths carry about three clocks of synchroniser delay
`timescale 1ns/1ns
module spll_properties (
  // clock and reset
  input wire       clock,
  input wire       rst,
  // serial pins
  input wire       sclk,
  input wire       cs_n,
  input wire       si,
  input wire       wp_n,
  input wire       so_out_reg,
  input wire       so_oe_reg,
  // protection state
  input wire [3:0] sector_protect,
  input wire       protection_lock_bit,
  input wire       hw_lock_reg,
  input wire [1:0] software_protection_summary
);
  // =====
  // helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // summary code expected for a protection pattern
  function [1:0] sum_of(input [3:0] p);
    sum_of = (p == 4'hf) ? 2'h3 : ((p == 4'h0) ? 2'h0 : 2'h1);
  endfunction
  // =====
  // assertions
  reset_val_a: assert property ($fell(rst) |-> sector_protect == 4'hf &&
    !protection_lock_bit && !so_oe_reg) else $error("bad state after reset");
  hw_on_a: assert property ((!wp_n && protection_lock_bit)[*5] |-> hw_lock_reg)
    else $error("hardware lock not raised");
  hw_off_a: assert property ((wp_n || !protection_lock_bit)[*5] |-> !hw_lock_reg)
    else $error("hardware lock raised without cause");
  hw_freeze_a: assert property ((!wp_n && hw_lock_reg)[*3] |=>
    $stable(protection_lock_bit) && $stable(sector_protect)) else $error("locked state moved");
  soft_lock_a: assert property (protection_lock_bit && $past(protection_lock_bit, 2)
    |-> $stable(sector_protect)) else $error("protection moved while locked");
  clear_no_glob_a: assert property ($fell(protection_lock_bit) |=>
    $stable(sector_protect)[*2]) else $error("global action on lock clear");
  oe_release_a: assert property (cs_n[*5] |-> !so_oe_reg)
    else $error("output still driven after deselect");
  oe_start_a: assert property ($rose(so_oe_reg) |-> !cs_n && !$past(cs_n, 4))
    else $error("output driven outside a frame");
  sum_track_a: assert property ($stable(sector_protect) |=>
    software_protection_summary == sum_of($past(sector_protect))) else $error("summary wrong");
  idle_hold_a: assert property (cs_n[*8] |-> $stable(sector_protect))
    else $error("protection moved with no command");
  // main scenarios reached
  cover property ($rose(hw_lock_reg));
  cover property ($rose(so_oe_reg));
  cover property ($fell(protection_lock_bit));
endmodule
bind spll_top spll_properties u_props (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .si(si), .wp_n(wp_n), .so_out_reg(so_out_reg), .so_oe_reg(so_oe_reg),
  .sector_protect(sector_protect), .protection_lock_bit(protection_lock_bit),
  .hw_lock_reg(hw_lock_reg), .software_protection_summary(software_protection_summary));

// ==== bench/spll_host.sv ====
// Purpose: serial host model issuing framed commands
// Assumes: mode 0, sclk idles low and stands still between frames
// Notes:   a floating output is read as noise, never as the last value
`timescale 1ns/1ns
module spll_host (
  // serial pins driven
  output reg  sclk,
  output reg  cs_n,
  output reg  si,
  // serial pins seen
  input  wire so_out_reg,
  input  wire so_oe_reg
);
  reg last;
  // idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
    last = 1'b0;
  end
  // one bit: data first, then rise, then fall
  task bit_out(input b);
    begin
      si = b;
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
    end
  endtask
  // opcode, nb bytes of a msb first, nr bits read, then deselect
  task xfer(input [7:0] op, input [1:0] nb, input [23:0] a, input [4:0] nr,
            output [15:0] q);
    integer i;
    begin
      q = 16'h0000;
      cs_n = 1'b0;
      for (i = 7; i >= 0; i = i - 1) bit_out(op[i]);
      for (i = 8 * nb - 1; i >= 0; i = i - 1) bit_out(a[i]);
      for (i = 0; i < nr; i = i + 1) begin
        #62 last = so_oe_reg ? so_out_reg : ~last;
        q = {q[14:0], last};
        sclk = 1'b1;
        #63 sclk = 1'b0;
      end
      #62 cs_n = 1'b1;
      si = ~si; // data line is meaningless while deselected
      #250;
    end
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench of the sector protection and lock block
// Assumes: host model drives the serial pins, bench drives the pin wp_n
// Notes:   each scenario but the wp_n release ends with a check of the protection state, the data read or so_oe_reg
`timescale 1ns/1ns
`include "spll_regs.vh"
module tb_top;
  reg        clock = 1'b0;
  reg        rst   = 1'b1;
  reg        wp_n  = 1'b1;
  reg [15:0] q;
  wire       sclk, cs_n, si, so_out_reg, so_oe_reg, lock, hw;
  wire [3:0] sector_protect;
  wire [1:0] summ;
  integer    n_mismatch = 0;
  integer    cmp_count  = 0;
  // =====
  // clock and units
  always #5 clock = ~clock;
  spll_top dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_out_reg(so_out_reg), .so_oe_reg(so_oe_reg), .sector_protect(sector_protect),
    .protection_lock_bit(lock), .hw_lock_reg(hw), .software_protection_summary(summ));
  spll_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out_reg(so_out_reg),
    .so_oe_reg(so_oe_reg));
  // =====
  // checks and verdict
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // summary expectation follows the protection pattern, not the design
  task state(input [3:0] p, input l, input h);
    chk({8'h00, sector_protect, lock, hw, summ},
      {8'h00, p, l, h, (p == 4'hf) ? `SPLL_SUM_ALL :
                       ((p == 4'h0) ? `SPLL_SUM_NONE : `SPLL_SUM_SOME)});
  endtask
  // =====
  // command tasks
  // frames start 1 ns after a clock edge so no pin ever moves on an edge
  task xf(input [7:0] op, input [1:0] nb, input [23:0] a, input [4:0] nr);
    begin
      @(posedge clock);
      #1;
      host.xfer(op, nb, a, nr, q);
    end
  endtask
  task wr_stat(input [7:0] d);
    xf(`SPLL_OP_WR_STAT, 2'd1, {16'h0000, d}, 5'd0);
  endtask
  task sec(input [7:0] op, input [1:0] s);
    xf(op, 2'd3, {6'h00, s, 16'h5a5a}, 5'd0);
  endtask
  task rd_stat(input [7:0] e);
    begin
      xf(`SPLL_OP_RD_STAT, 2'd0, 24'h000000, 5'd8);
      chk(q, {8'h00, e});
    end
  endtask
  task rd_sec(input [1:0] s, input [7:0] e);
    begin
      xf(`SPLL_OP_RD_SECT, 2'd3, {6'h00, s, 16'h1234}, 5'd16);
      chk(q, {e, e});
    end
  endtask
  task set_wp(input v);
    begin
      @(posedge clock) #1 wp_n = v;
      repeat (6) @(posedge clock);
    end
  endtask
  // =====
  // main sequence; wp_n high reads 1 in status bit 4
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    state(4'hf, 1'b0, 1'b0); // all protected after reset
    rd_stat(8'h1c); // pin and summary shown
    wr_stat(8'h00); state(4'h0, 1'b0, 1'b0); // global unprotect
    rd_stat(8'h10); // none protected
    sec(`SPLL_OP_PROT_SEC, 2'd2); state(4'h4, 1'b0, 1'b0); // one sector
    rd_sec(2'd2, 8'hff); // protected sector
    rd_sec(2'd1, 8'h00); // unprotected sector
    set_wp(1'b0); state(4'h4, 1'b0, 1'b0); // pin alone changes nothing
    rd_sec(2'd2, 8'hff); // pin not visible
    rd_stat(8'h04); // pin low, some protected
    wr_stat(8'h7f); state(4'hf, 1'b0, 1'b0); // global protect
    rd_stat(8'h0c); // written bits not stored
    set_wp(1'b1); // pin released
    sec(`SPLL_OP_UNPR_SEC, 2'd0); state(4'he, 1'b0, 1'b0); // sector unprotect
    wr_stat(8'hf0); state(4'he, 1'b1, 1'b0); // lock only
    sec(`SPLL_OP_PROT_SEC, 2'd0); state(4'he, 1'b1, 1'b0); // soft lock
    sec(`SPLL_OP_UNPR_SEC, 2'd1); state(4'he, 1'b1, 1'b0); // soft lock
    wr_stat(8'h00); state(4'he, 1'b0, 1'b0); // clear only
    wr_stat(8'h00); state(4'h0, 1'b0, 1'b0); // second write acts
    wr_stat(8'h44); state(4'h0, 1'b0, 1'b0); // other pattern
    wr_stat(8'hff); state(4'hf, 1'b1, 1'b0); // protect and lock
    wr_stat(8'h0f); state(4'hf, 1'b0, 1'b0); // unlock only
    wr_stat(8'h80); state(4'h0, 1'b1, 1'b0); // lock with unprotect
    set_wp(1'b0); state(4'h0, 1'b1, 1'b1); // hardware lock on
    wr_stat(8'h00); state(4'h0, 1'b1, 1'b1); // status write ignored
    sec(`SPLL_OP_PROT_SEC, 2'd3); state(4'h0, 1'b1, 1'b1); // protect ignored
    set_wp(1'b1); state(4'h0, 1'b1, 1'b0); // hardware lock off
    xf(`SPLL_OP_RD_SECT, 2'd3, 24'h030000, 5'd4); // cut mid-byte
    chk(q, 16'h0000); // partial byte read
    chk({15'h0000, so_oe_reg}, 16'h0000); // output floated
    wrap_up;
  end
  // hang guard
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule
